// ==== logic/serial_cfg_pkg.sv ====
package serial_cfg_pkg;

	// ****************************************
	// Widths and address areas
	// ****************************************
	localparam int ADDR_W = 10;
	localparam int DATA_W = 22;
	localparam int REG_W = 6;
	localparam int LINE_CNT_W = 12;
	localparam int MEM_DEPTH = 1024;
	localparam int STAGE_DEPTH = 256;
	localparam logic [4:0] FW_REG = 5'h06;
	localparam logic [4:0] FW_FAST = 5'h10;
	localparam logic [4:0] FW_PROG = 5'h16;
	localparam logic [9:0] FAST_BASE = 10'h100;
	localparam logic [9:0] PROG_BASE = 10'h180;
	localparam logic [9:0] MEM_BASE = 10'h100;

	// ****************************************
	// Register offsets and update groups
	// ****************************************
	localparam logic [9:0] A_UPDATE_SEL = 10'h000;
	localparam logic [9:0] FE_FIRST = 10'h001;
	localparam logic [9:0] FE_LAST = 10'h01F;
	localparam logic [9:0] A_SYNC_CTRL = 10'h020;
	localparam logic [9:0] A_ODD_LIMIT = 10'h02F;
	localparam logic [9:0] A_HCNT_LAT = 10'h034;
	localparam logic [9:0] A_SPLIT = 10'h036;
	localparam logic [9:0] TG_FIRST = 10'h037;
	localparam logic [9:0] TG_LAST = 10'h0FF;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int FE_DEFER_BIT = 0;
	localparam int EVT_SEL_LO = 1;
	localparam int TG_DEFER_BIT = 3;
	localparam int SYNC_EDGE_BIT = 3;
	localparam logic [5:0] UPDATE_SEL_RST = 6'h00;
	localparam logic [5:0] ODD_LIMIT_RST = 6'h09;
	localparam logic [3:0] HCNT_LAT_RST = 4'h6;
	localparam logic [1:0] EVT_LOAD_RISE = 2'h0;
	localparam logic [1:0] EVT_LOAD_FALL = 2'h1;
	localparam logic [1:0] EVT_VS_RISE = 2'h2;
	localparam logic [1:0] EVT_VS_FALL = 2'h3;
	localparam logic [2:0] SINCE_SAT = 3'h7;
	localparam int LATCH_MAX_CYC = 10;

	typedef struct packed {
		logic valid;
		logic [9:0] addr;
		logic [21:0] data;
	} reg_write_s;

	typedef enum logic [1:0] {
		FL_IDLE = 2'b01,
		FL_SCAN = 2'b10
	} flush_state_e;

	function automatic logic [4:0] field_width(input logic [9:0] a);
		if (a >= PROG_BASE) begin
			return FW_PROG;
		end else if (a >= FAST_BASE) begin
			return FW_FAST;
		end else begin
			return FW_REG;
		end
	endfunction

endpackage

// ==== logic/sync_edge.sv ====
`timescale 1ns/1ps
module sync_edge (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic pin_in,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta_q;
	logic sync_q;
	logic prev_q;
	logic [2:0] arm_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
			arm_q <= 3'h0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
			arm_q <= {arm_q[1:0], 1'b1};
		end
	end

	// Edges stay masked until the pipe holds real pin history, so an idle-high pin gives no false edge
	assign level = sync_q;
	assign rise = sync_q & ~prev_q & arm_q[2];
	assign fall = ~sync_q & prev_q & arm_q[2];
endmodule // sync_edge

// ==== logic/word_ram.sv ====
`timescale 1ns/1ps
module word_ram #(
	parameter int W = 22,
	parameter int D = 1024,
	parameter int AW = 10
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic re,
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	// Array has no reset so it maps onto block memory
	logic [W-1:0] mem [D];

	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rdata <= '0;
		end else if (re) begin
			rdata <= mem[raddr];
		end
	end
endmodule // word_ram

// ==== logic/serial_config_write_port.sv ====
`timescale 1ns/1ps
// What this block does
// - Shift data on serial clock rise while selected
// - Command is 10-bit address plus data field
// - Field width follows address area: 6/16/22
// - Standard write lands at select rising edge
// - Leftover partial field is discarded
// - Continuous mode writes each field, address increments
// - Register area: longer transfers become continuous words
// - Memory areas ignore short transfers, count whole fields
// - Immediate-update data reaches registers within ten cycles
// - Program write during engine read cancels operation
// - Address space of 1024 words in areas
// - Per-address update timing groups
// - Front-end update: immediate or deferred by bit
// - Deferred source: load pin or vsync edges
// - Timing update: immediate or at line event
// - Vsync trail delay limit for odd field
// - Hsync trail delay limit for odd field
// - Syncs sampled on master clock rising edge
// - Hsync detection resets line counter, edge selectable
// - Line counter reset latency programmable, default six
module serial_config_write_port (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic serial_clock_in,
	input wire logic select_n,
	input wire logic serial_data_in,
	input wire logic vertical_sync,
	input wire logic horizontal_sync,
	input wire logic load_strobe_pin,
	input wire logic external_trigger_in,
	input wire logic tg_line_update,
	input wire logic program_read_busy,
	input wire logic prog_rd_en,
	input wire logic [9:0] prog_rd_addr,
	output logic [21:0] prog_rd_data,
	output serial_cfg_pkg::reg_write_s reg_apply,
	output logic program_cancel,
	output logic [5:0] update_select,
	output logic [2:0] vsync_field_bits,
	output logic [2:0] trigger_field_bits,
	output logic field_odd,
	output logic line_reset,
	output logic [11:0] line_pixel_counter
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic in_fe(input logic [9:0] a);
		return (a >= serial_cfg_pkg::FE_FIRST) && (a <= serial_cfg_pkg::FE_LAST);
	endfunction

	function automatic logic in_tg(input logic [9:0] a);
		return (a >= serial_cfg_pkg::TG_FIRST) && (a <= serial_cfg_pkg::TG_LAST);
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Serial clock is oversampled by clk_sys; a serial period must exceed about three system clocks.
	wire sclk_rise;
	wire serial_data_in_lvl;
	wire sel_lvl;
	wire sel_rise;
	wire vs_rise;
	wire vs_fall;
	wire hs_rise;
	wire hs_fall;
	wire ld_rise;
	wire ld_fall;
	wire external_trigger_in_rise;

	sync_edge u_sclk (.clk_sys(clk_sys), .resetn(resetn), .pin_in(serial_clock_in),
		.level(), .rise(sclk_rise), .fall());
	sync_edge u_serial_data_in (.clk_sys(clk_sys), .resetn(resetn), .pin_in(serial_data_in),
		.level(serial_data_in_lvl), .rise(), .fall());
	sync_edge u_sel (.clk_sys(clk_sys), .resetn(resetn), .pin_in(select_n),
		.level(sel_lvl), .rise(sel_rise), .fall());
	sync_edge u_vs (.clk_sys(clk_sys), .resetn(resetn), .pin_in(vertical_sync),
		.level(), .rise(vs_rise), .fall(vs_fall));
	sync_edge u_hs (.clk_sys(clk_sys), .resetn(resetn), .pin_in(horizontal_sync),
		.level(), .rise(hs_rise), .fall(hs_fall));
	sync_edge u_ld (.clk_sys(clk_sys), .resetn(resetn), .pin_in(load_strobe_pin),
		.level(), .rise(ld_rise), .fall(ld_fall));
	sync_edge u_external_trigger_in (.clk_sys(clk_sys), .resetn(resetn), .pin_in(external_trigger_in),
		.level(), .rise(external_trigger_in_rise), .fall());

	// ****************************************
	// Serial shift and field assembly
	// ****************************************
	logic [3:0] addr_cnt_q;
	logic addr_done_q;
	logic [9:0] addr_q;
	logic [4:0] fcnt_q;
	logic [21:0] field_q;
	logic full_q;

	wire bit_evt = sclk_rise & ~sel_lvl;
	wire [4:0] cur_width = serial_cfg_pkg::field_width(addr_q);
	wire [4:0] fcnt_inc = fcnt_q + 5'h01;
	wire data_evt = bit_evt & addr_done_q;
	// A finished field is committed when the next bit shows continuation, or when select rises
	wire commit = full_q & (data_evt | sel_rise);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			addr_cnt_q <= 4'h0;
			addr_done_q <= 1'b0;
			addr_q <= 10'h000;
			fcnt_q <= 5'h00;
			field_q <= 22'h000000;
			full_q <= 1'b0;
		end else if (sel_lvl) begin
			addr_cnt_q <= 4'h0;
			addr_done_q <= 1'b0;
			fcnt_q <= 5'h00;
			field_q <= 22'h000000;
			full_q <= 1'b0;
		end else if (bit_evt) begin
			if (!addr_done_q) begin
				addr_q[addr_cnt_q] <= serial_data_in_lvl;
				addr_cnt_q <= addr_cnt_q + 4'h1;
				addr_done_q <= (addr_cnt_q == 4'h9);
			end else if (full_q) begin
				addr_q <= addr_q + 10'h001;
				field_q <= {21'h000000, serial_data_in_lvl};
				fcnt_q <= 5'h01;
				full_q <= 1'b0;
			end else begin
				field_q[fcnt_q] <= serial_data_in_lvl;
				fcnt_q <= fcnt_inc;
				full_q <= (fcnt_inc == cur_width);
			end
		end
	end

	// ****************************************
	// Commit routing
	// ****************************************
	logic [5:0] update_sel_q;
	logic [1:0] sync_ctrl_q;
	logic [5:0] odd_limit_q;
	logic [3:0] hcnt_lat_q;

	wire is_prog = commit & (addr_q >= serial_cfg_pkg::MEM_BASE);
	wire is_split = commit & (addr_q == serial_cfg_pkg::A_SPLIT);
	wire stage_fe = commit & in_fe(addr_q) & update_sel_q[serial_cfg_pkg::FE_DEFER_BIT];
	wire stage_tg = commit & in_tg(addr_q) & update_sel_q[serial_cfg_pkg::TG_DEFER_BIT];
	wire stage_wr = stage_fe | stage_tg;
	wire ser_main_we = commit & ~stage_wr & ~is_split;

	// ****************************************
	// Deferred update flush
	// ****************************************
	serial_cfg_pkg::flush_state_e st_q;
	logic [255:0] pend_q;
	logic fe_arm_q;
	logic tg_arm_q;
	logic fe_act_q;
	logic tg_act_q;
	logic [7:0] idx_q;
	logic copy_q;
	logic [7:0] copy_idx_q;
	wire [5:0] stage_rdata;

	wire [1:0] evt_sel = update_sel_q[serial_cfg_pkg::EVT_SEL_LO +: 2];
	wire fe_evt = (evt_sel == serial_cfg_pkg::EVT_LOAD_RISE) ? ld_rise :
		(evt_sel == serial_cfg_pkg::EVT_LOAD_FALL) ? ld_fall :
		(evt_sel == serial_cfg_pkg::EVT_VS_RISE) ? vs_rise : vs_fall;
	// Serial writes own the memory port; the flush simply waits a cycle
	wire stall = ser_main_we;
	wire [9:0] idx_addr = {2'b00, idx_q};
	wire scanning = (st_q == serial_cfg_pkg::FL_SCAN);
	wire hit = scanning & pend_q[idx_q] & ((fe_act_q & in_fe(idx_addr)) | (tg_act_q & in_tg(idx_addr)));
	wire rd_issue = hit & ~stall;
	wire copy_we = copy_q & ~stall;

	word_ram #(.W(serial_cfg_pkg::REG_W), .D(serial_cfg_pkg::STAGE_DEPTH), .AW(8)) u_stage (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.we(stage_wr),
		.waddr(addr_q[7:0]),
		.wdata(field_q[5:0]),
		.re(rd_issue),
		.raddr(idx_q),
		.rdata(stage_rdata)
	);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			fe_arm_q <= 1'b0;
			tg_arm_q <= 1'b0;
		end else begin
			fe_arm_q <= fe_evt | (fe_arm_q & scanning);
			tg_arm_q <= tg_line_update | (tg_arm_q & scanning);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_q <= serial_cfg_pkg::FL_IDLE;
			fe_act_q <= 1'b0;
			tg_act_q <= 1'b0;
			idx_q <= 8'h00;
		end else begin
			case (st_q)
				serial_cfg_pkg::FL_IDLE: begin
					if (fe_arm_q | tg_arm_q) begin
						st_q <= serial_cfg_pkg::FL_SCAN;
						fe_act_q <= fe_arm_q;
						tg_act_q <= tg_arm_q;
						idx_q <= 8'h00;
					end
				end
				serial_cfg_pkg::FL_SCAN: begin
					if (!stall) begin
						idx_q <= idx_q + 8'h01;
						if (idx_q == 8'hFF) begin
							st_q <= serial_cfg_pkg::FL_IDLE;
						end
					end
				end
				default: begin
					st_q <= serial_cfg_pkg::FL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			copy_q <= 1'b0;
			copy_idx_q <= 8'h00;
		end else if (!stall) begin
			copy_q <= rd_issue;
			copy_idx_q <= idx_q;
		end
	end

	// New staging wins over a flush clearing the same slot
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pend_q <= '0;
		end else begin
			if (copy_we) begin
				pend_q[copy_idx_q] <= 1'b0;
			end
			if (stage_wr) begin
				pend_q[addr_q[7:0]] <= 1'b1;
			end
		end
	end

	// ****************************************
	// Main register and program memory
	// ****************************************
	wire main_we = ser_main_we | copy_we;
	wire [9:0] main_addr = ser_main_we ? addr_q : {2'b00, copy_idx_q};
	wire [21:0] main_data = ser_main_we ? field_q : {16'h0000, stage_rdata};

	// Data lands one cycle after the commit, well inside the ten-cycle budget
	word_ram #(.W(serial_cfg_pkg::DATA_W), .D(serial_cfg_pkg::MEM_DEPTH), .AW(serial_cfg_pkg::ADDR_W)) u_main (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.we(main_we),
		.waddr(main_addr),
		.wdata(main_data),
		.re(prog_rd_en),
		.raddr(prog_rd_addr),
		.rdata(prog_rd_data)
	);

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			reg_apply <= '0;
			program_cancel <= 1'b0;
		end else begin
			reg_apply.valid <= main_we;
			reg_apply.addr <= main_addr;
			reg_apply.data <= main_data;
			program_cancel <= is_prog & program_read_busy;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			update_sel_q <= serial_cfg_pkg::UPDATE_SEL_RST;
			sync_ctrl_q <= 2'h0;
			odd_limit_q <= serial_cfg_pkg::ODD_LIMIT_RST;
			hcnt_lat_q <= serial_cfg_pkg::HCNT_LAT_RST;
		end else if (main_we) begin
			if (main_addr == serial_cfg_pkg::A_UPDATE_SEL) begin
				update_sel_q <= main_data[5:0];
			end else if (main_addr == serial_cfg_pkg::A_SYNC_CTRL) begin
				sync_ctrl_q <= main_data[3:2];
			end else if (main_addr == serial_cfg_pkg::A_ODD_LIMIT) begin
				odd_limit_q <= main_data[5:0];
			end else if (main_addr == serial_cfg_pkg::A_HCNT_LAT) begin
				hcnt_lat_q <= main_data[3:0];
			end
		end
	end

	assign update_select = update_sel_q;

	// ****************************************
	// Split register: vsync and trigger halves
	// ****************************************
	logic [5:0] split_stage_q;
	logic split_lo_q;
	logic split_hi_q;

	wire hs_det = sync_ctrl_q[1] ? hs_rise : hs_fall;
	wire vs_det = sync_ctrl_q[1] ? vs_rise : vs_fall;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			split_stage_q <= 6'h00;
			split_lo_q <= 1'b0;
			split_hi_q <= 1'b0;
			vsync_field_bits <= 3'h0;
			trigger_field_bits <= 3'h0;
		end else begin
			if (is_split) begin
				split_stage_q <= field_q[5:0];
			end
			split_lo_q <= is_split | (split_lo_q & ~vs_det);
			split_hi_q <= is_split | (split_hi_q & ~external_trigger_in_rise);
			if (vs_det & split_lo_q) begin
				vsync_field_bits <= split_stage_q[2:0];
			end
			if (external_trigger_in_rise & split_hi_q) begin
				trigger_field_bits <= split_stage_q[5:3];
			end
		end
	end

	// ****************************************
	// Odd field detection
	// ****************************************
	logic [2:0] since_hs_q;
	logic [2:0] since_vs_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			since_hs_q <= serial_cfg_pkg::SINCE_SAT;
			since_vs_q <= serial_cfg_pkg::SINCE_SAT;
			field_odd <= 1'b0;
		end else begin
			since_hs_q <= hs_det ? 3'h0 : (since_hs_q == serial_cfg_pkg::SINCE_SAT) ? since_hs_q : since_hs_q + 3'h1;
			since_vs_q <= vs_det ? 3'h0 : (since_vs_q == serial_cfg_pkg::SINCE_SAT) ? since_vs_q : since_vs_q + 3'h1;
			if (vs_det) begin
				field_odd <= hs_det | (since_hs_q <= odd_limit_q[2:0]);
			end else if (hs_det & (since_vs_q <= odd_limit_q[5:3])) begin
				field_odd <= 1'b1;
			end
		end
	end

	// ****************************************
	// Line pixel counter reset
	// ****************************************
	logic [3:0] lat_cnt_q;
	logic lat_run_q;

	wire lat_fire = (hs_det & (hcnt_lat_q == 4'h0)) | (lat_run_q & (lat_cnt_q == 4'h1));

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			lat_cnt_q <= 4'h0;
			lat_run_q <= 1'b0;
			line_reset <= 1'b0;
			line_pixel_counter <= 12'h000;
		end else begin
			if (hs_det) begin
				lat_cnt_q <= hcnt_lat_q;
				lat_run_q <= (hcnt_lat_q != 4'h0);
			end else if (lat_run_q) begin
				lat_cnt_q <= lat_cnt_q - 4'h1;
				lat_run_q <= (lat_cnt_q != 4'h1);
			end
			line_reset <= lat_fire;
			line_pixel_counter <= lat_fire ? 12'h000 : line_pixel_counter + 12'h001;
		end
	end

endmodule // serial_config_write_port

// ==== testbench/serial_cfg_monitor.sv ====
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module serial_cfg_monitor (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic horizontal_sync,
	input wire logic program_read_busy,
	input wire serial_cfg_pkg::reg_write_s reg_apply,
	input wire logic program_cancel,
	input wire logic [5:0] update_select,
	input wire logic line_reset,
	input wire logic [11:0] line_pixel_counter
);
	logic [1:0] up_q;
	logic up_ok;
	// Past values straddling reset are meaningless, so relations over history other than the cancel cause check wait a few edges
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			up_q <= 2'h0;
		end else if (up_q != 2'h3) begin
			up_q <= up_q + 2'h1;
		end
	end
	assign up_ok = (up_q == 2'h3);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	reg_width_a: assert property (reg_apply.valid && reg_apply.addr < serial_cfg_pkg::FAST_BASE |->
		reg_apply.data[21:6] == 16'h0000) else $error("register word wider than six bits");
	fast_width_a: assert property (reg_apply.valid && reg_apply.addr >= serial_cfg_pkg::FAST_BASE &&
		reg_apply.addr < serial_cfg_pkg::PROG_BASE |-> reg_apply.data[21:16] == 6'h00)
		else $error("fast word wider than sixteen bits");
	sel_update_a: assert property (up_ok && $changed(update_select) |-> reg_apply.valid &&
		reg_apply.addr == 10'h000 && reg_apply.data[5:0] == update_select)
		else $error("update select moved without a write");
	cancel_cause_a: assert property (program_cancel |-> $past(program_read_busy) ||
		$past(program_read_busy, 2)) else $error("cancel without engine read");
	cancel_pulse_a: assert property (program_cancel |=> !program_cancel)
		else $error("cancel longer than one cycle");
	reset_pulse_a: assert property (line_reset |=> !line_reset)
		else $error("line reset longer than one cycle");
	hs_latency_a: assert property (up_ok && $fell(horizontal_sync) |-> ##[7:12] line_reset)
		else $error("line reset late after sync edge");
	count_run_a: assert property (up_ok && !line_reset ##1 !line_reset |->
		line_pixel_counter == $past(line_pixel_counter) + 12'h001) else $error("line counter stalled");
	cover property (reg_apply.valid && reg_apply.addr >= serial_cfg_pkg::PROG_BASE);
	cover property (program_cancel);
	cover property (line_reset);
endmodule // serial_cfg_monitor

bind serial_config_write_port serial_cfg_monitor mon (
	.clk_sys(clk_sys),
	.resetn(resetn),
	.horizontal_sync(horizontal_sync),
	.program_read_busy(program_read_busy),
	.reg_apply(reg_apply),
	.program_cancel(program_cancel),
	.update_select(update_select),
	.line_reset(line_reset),
	.line_pixel_counter(line_pixel_counter)
);

// ==== testbench/serial_host_model.sv ====
`timescale 1ns/1ps
// ****************************************
// Serial host, clock idles low between frames
// ****************************************
module serial_host_model (
	input wire logic clk_sys,
	output logic serial_clock_in,
	output logic select_n,
	output logic serial_data_in
);
	initial begin
		serial_clock_in = 1'b0;
		select_n = 1'b1;
		serial_data_in = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// A count short of a whole field leaves a ragged tail on purpose
	task automatic send(input logic [9:0] a, input logic [31:0] d, input int nb);
		logic [41:0] w;
		w = {d, a};
		tick(1);
		select_n = 1'b0;
		for (int i = 0; i < nb; i++) begin
			serial_data_in = w[i];
			tick(4);
			serial_clock_in = 1'b1;
			tick(4);
			serial_clock_in = 1'b0;
		end
		tick(4);
		select_n = 1'b1;
		serial_data_in = ~serial_data_in;
		tick(4);
	endtask
	// Toggling while deselected must leave no trace
	task automatic noise(input int n);
		for (int i = 0; i < n; i++) begin
			serial_data_in = i[0];
			serial_clock_in = ~serial_clock_in;
			tick(4);
		end
		serial_clock_in = 1'b0;
	endtask
endmodule // serial_host_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	logic clk_sys, resetn, vertical_sync, horizontal_sync, load_strobe_pin, external_trigger_in;
	logic tg_line_update, program_read_busy, prog_rd_en, program_cancel, field_odd, line_reset;
	logic serial_clock_in, select_n, serial_data_in;
	logic [9:0] prog_rd_addr;
	logic [21:0] prog_rd_data;
	logic [5:0] update_select;
	logic [2:0] vsync_field_bits, trigger_field_bits;
	logic [11:0] line_pixel_counter;
	logic [31:0] d2;
	serial_cfg_pkg::reg_write_s reg_apply;
	serial_cfg_pkg::reg_write_s exp_q[$];
	logic [9:0] tbl_a [10] = '{10'h02A, 10'h021, 10'h040, 10'h100, 10'h100, 10'h160, 10'h180, 10'h180, 10'h200, 10'h1FE};
	int tbl_n [10] = '{6, 22, 32, 6, 32, 22, 16, 32, 22, 32};
	int num_errors = 0, check_count = 0, cancel_cnt = 0, lr_cnt = 0, cyc = 0;
	integer seed = 32'hC51BB8DD;

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	serial_config_write_port dut (.clk_sys(clk_sys), .resetn(resetn), .serial_clock_in(serial_clock_in),
		.select_n(select_n), .serial_data_in(serial_data_in), .vertical_sync(vertical_sync),
		.horizontal_sync(horizontal_sync), .load_strobe_pin(load_strobe_pin),
		.external_trigger_in(external_trigger_in), .tg_line_update(tg_line_update),
		.program_read_busy(program_read_busy), .prog_rd_en(prog_rd_en), .prog_rd_addr(prog_rd_addr),
		.prog_rd_data(prog_rd_data), .reg_apply(reg_apply), .program_cancel(program_cancel),
		.update_select(update_select), .vsync_field_bits(vsync_field_bits),
		.trigger_field_bits(trigger_field_bits), .field_odd(field_odd), .line_reset(line_reset),
		.line_pixel_counter(line_pixel_counter));
	serial_host_model host (.clk_sys(clk_sys), .serial_clock_in(serial_clock_in), .select_n(select_n),
		.serial_data_in(serial_data_in));

	// ****************************************
	// Checking and reporting
	// ****************************************
	task automatic check_val(input string name, input logic [21:0] exp, input logic [21:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic check_apply(input serial_cfg_pkg::reg_write_s exp, input serial_cfg_pkg::reg_write_s got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED reg_apply expected %h seen %h", exp, got);
		end
	endtask
	task automatic results;
		if (num_errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Expected words: only whole fields, at rising addresses
	task automatic wr(input logic [9:0] a, input int nd, input logic [31:0] d, input bit settle);
		int w;
		serial_cfg_pkg::reg_write_s e;
		w = (a >= 10'h180) ? 22 : ((a >= 10'h100) ? 16 : 6);
		for (int k = 0; k < nd / w; k++) begin
			e.valid = 1'b1;
			e.addr = a + k[9:0];
			e.data = 22'((d >> (k * w)) & ((32'h1 << w) - 32'h1));
			exp_q.push_back(e);
		end
		host.send(a, d, 10 + nd);
		if (settle) begin
			for (int t = 0; t < 60 && exp_q.size() != 0; t++) @(posedge clk_sys);
			#1;
			check_val("pending words", 22'h0, 22'(exp_q.size()));
		end
	endtask
	task automatic rd(input logic [9:0] a, input logic [21:0] exp);
		step(1);
		prog_rd_en = 1'b1;
		prog_rd_addr = a;
		step(1);
		prog_rd_en = 1'b0;
		check_val("prog_rd_data", exp, prog_rd_data);
	endtask

	// Outputs are looked at mid-cycle, well away from the edge that launches them
	always @(negedge clk_sys) begin
		cyc++;
		if (resetn === 1'b1 && program_cancel === 1'b1) cancel_cnt++;
		if (resetn === 1'b1 && line_reset === 1'b1) lr_cnt++;
		if (resetn === 1'b1 && reg_apply.valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check_apply('0, reg_apply);
			end else begin
				check_apply(exp_q.pop_front(), reg_apply);
			end
		end
		if (cyc > 20000) begin
			num_errors++;
			results();
		end
	end

	initial begin
		resetn = 1'b0;
		vertical_sync = 1'b0;
		horizontal_sync = 1'b1;
		load_strobe_pin = 1'b0;
		external_trigger_in = 1'b0;
		tg_line_update = 1'b0;
		program_read_busy = 1'b0;
		prog_rd_en = 1'b0;
		prog_rd_addr = 10'h000;
		step(20);
		resetn = 1'b1;
		step(4);
		check_val("update_select", 22'(serial_cfg_pkg::UPDATE_SEL_RST), 22'(update_select));
		for (int i = 0; i < 10; i++) wr(tbl_a[i], tbl_n[i], $random(seed), 1'b1);
		d2 = $random(seed);
		wr(10'h200, 22, d2, 1'b1);
		rd(10'h200, d2[21:0]);
		host.send(10'h02B, 32'h0000003F, 8);
		host.noise(6);
		wr(10'h02B, 6, $random(seed), 1'b1);
		program_read_busy = 1'b1;
		wr(10'h190, 22, $random(seed), 1'b1);
		program_read_busy = 1'b0;
		check_val("cancel pulses", 22'h1, 22'(cancel_cnt));
		wr(10'h000, 6, 32'h1, 1'b1);
		check_val("update_select", 22'h1, 22'(update_select));
		wr(10'h005, 6, $random(seed), 1'b0);
		step(40);
		check_val("deferred words", 22'h1, 22'(exp_q.size()));
		load_strobe_pin = 1'b1;
		for (int t = 0; t < 400 && exp_q.size() != 0; t++) @(posedge clk_sys);
		#1;
		check_val("deferred words", 22'h0, 22'(exp_q.size()));
		load_strobe_pin = 1'b0;
		wr(10'h000, 6, 32'h8, 1'b1);
		check_val("update_select", 22'h8, 22'(update_select));
		wr(10'h050, 6, $random(seed), 1'b0);
		step(40);
		check_val("deferred words", 22'h1, 22'(exp_q.size()));
		tg_line_update = 1'b1;
		step(1);
		tg_line_update = 1'b0;
		for (int t = 0; t < 400 && exp_q.size() != 0; t++) @(posedge clk_sys);
		#1;
		check_val("deferred words", 22'h0, 22'(exp_q.size()));
		for (int i = 0; i < 3; i++) begin
			horizontal_sync = 1'b0;
			step(20);
			horizontal_sync = 1'b1;
			step(20);
		end
		check_val("line resets", 22'h3, 22'(lr_cnt));
		d2 = $random(seed);
		host.send(10'h036, d2, 16);
		vertical_sync = 1'b1;
		step(10);
		horizontal_sync = 1'b0;
		vertical_sync = 1'b0;
		step(12);
		check_val("field_odd", 22'h1, 22'(field_odd));
		check_val("vsync_field_bits", 22'(d2[2:0]), 22'(vsync_field_bits));
		check_val("trigger_field_bits", 22'h0, 22'(trigger_field_bits));
		external_trigger_in = 1'b1;
		step(10);
		check_val("trigger_field_bits", 22'(d2[5:3]), 22'(trigger_field_bits));
		horizontal_sync = 1'b1;
		vertical_sync = 1'b1;
		step(20);
		vertical_sync = 1'b0;
		step(10);
		check_val("field_odd", 22'h0, 22'(field_odd));
		vertical_sync = 1'b1;
		step(10);
		vertical_sync = 1'b0;
		step(1);
		horizontal_sync = 1'b0;
		step(20);
		check_val("field_odd", 22'h1, 22'(field_odd));
		results();
	end
endmodule // tb_top
